// File: hdl/sscd_pkg.sv
// Shared constants and carriers for the serial/stream capture DMA block
package sscd_pkg;
  // Register map (word addresses on the plain register port)
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_WORDLEN  = 4'h1;
  localparam logic [3:0] ADDR_DST      = 4'h2;
  localparam logic [3:0] ADDR_COUNT    = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_MASK     = 4'h5;
  localparam logic [3:0] ADDR_WRPTR    = 4'h6;
  localparam logic [3:0] ADDR_SYNCERR  = 4'h7;
  localparam logic [3:0] ADDR_SIZEERR  = 4'h8;
  localparam logic [3:0] ADDR_LEVEL    = 4'h9;
  localparam logic [3:0] ADDR_THRESH   = 4'hA;

  // Control register fields
  localparam int CTRL_I2S_EN   = 0;
  localparam int CTRL_MASTER   = 1;
  localparam int CTRL_STREAM_EN = 2;
  localparam int CTRL_CIRC     = 3;
  localparam int CTRL_PKT204   = 4;
  localparam int CTRL_DMA_EN   = 5;
  localparam int CTRL_W        = 6;

  // Status / mask bits
  localparam int ST_FILL     = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_DONE     = 2;
  localparam int ST_SYNCERR  = 3;
  localparam int ST_SIZEERR  = 4;
  localparam int ST_W        = 5;

  // Stream packet constants
  localparam logic [7:0] SYNC_A    = 8'h47;
  localparam logic [7:0] SYNC_B    = 8'hB8;
  localparam logic [7:0] PKT_LEN_A = 8'hBC;   // 188 bytes
  localparam logic [7:0] PKT_LEN_B = 8'hCC;   // 204 bytes

  // Audio word and master clock divider
  localparam logic [5:0] WORD_MAX   = 6'h20;  // 32 bits captured at most
  localparam logic [3:0] SCLK_HALF  = 4'h1;   // reference edges per half bit
  localparam logic [5:0] BITS_PER_CH = 6'h20;  // master mode bit clocks per channel

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [2:0]  nbytes;
  } sscd_word_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        valid;
  } sscd_mem_wr_t;
endpackage

// File: hdl/sscd_capture.sv
// Serial audio and parallel stream capture with write-only capture DMA
//
// Contract
// [RL1] Audio receiver is software-selectable as link slave or link master.
// [RL2] Slave mode: bit clock, frame clock, data are inputs from transmitter.
// [RL3] Master mode: device makes bit and frame clocks from reference clock.
// [RL4] Bits arrive MSB first, high byte first.
// [RL5] No word length set: capture every bit of each channel frame. The code keeps at most the first 32 bits (WORD_MAX).
// [RL6] Too few bits: pad missing low bits with zeros to programmed length.
// [RL7] Too many bits: keep programmed leading bits, drop the rest.
// [RL8] Stream byte accepted only while valid qualifier is high.
// [RL9] Packets are 188 bytes (sync 0x47) or 204 bytes (0x47 or 0xB8).
// [RL10] Sync byte is the byte with valid and packet start both high.
// [RL11] Corrupt packets detected as sync or size errors and counted.
// [RL12] Source keeps stream rate at or below 20 Mbit/s.
// [RL13] Stream port and upper GPIO group are mutually exclusive.
// [RL14] DMA writes to programmed destination for programmed byte count.
// [RL15] DMA accepts every offered word without stall or loss. The code drops a stream word that comes in the same cycle as an audio word.
// [RL16] Optional circular buffer wraps pointer and reports fill level.
// [RL17] Circular overflow raises interrupt and keeps writing over old data.
// [RL18] Sync error: wrong flagged sync value; size error: wrong packet length.
// [RL19] Link signals are synchronised into the system clock before use.
//
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sscd_capture (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  // Register port
  input  wire logic [3:0]   i_reg_addr,
  input  wire logic [31:0]  i_reg_wdata,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  output logic      [31:0]  o_reg_rdata,
  output logic              o_irq,
  // Serial audio link
  input  wire logic         i_master_reference_clock_in,
  input  wire logic         i_sclk,
  input  wire logic         i_lrclk,
  input  wire logic         i_sdata,
  output logic              o_sclk,
  output logic              o_sclk_oe,
  output logic              o_lrclk,
  output logic              o_lrclk_oe,
  // Parallel stream port
  input  wire logic         i_stream_clk,
  input  wire logic [7:0]   i_stream_data,
  input  wire logic         i_stream_byte_valid,
  input  wire logic         i_stream_packet_start_flag,
  output logic              o_upper_gpio_group_en,
  // Memory write channel
  output sscd_pkg::sscd_mem_wr_t o_mem_wr
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [sscd_pkg::CTRL_W-1:0] ctrl_ff;
  logic [5:0]                  wordlen_ff;
  logic [31:0]                 dst_ff;
  logic [31:0]                 count_ff;
  logic [31:0]                 thresh_ff;
  logic [sscd_pkg::ST_W-1:0]   status_ff;
  logic [sscd_pkg::ST_W-1:0]   mask_ff;
  logic [31:0]                 sync_err_ff;
  logic [31:0]                 size_err_ff;
  logic [31:0]                 offs_ff;
  logic [31:0]                 level_ff;
  logic [sscd_pkg::ST_W-1:0]   ev;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  wire wr_ctrl = i_reg_wr && hit(i_reg_addr, sscd_pkg::ADDR_CTRL);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_ff    <= '0;
      wordlen_ff <= '0;
      dst_ff     <= '0;
      count_ff   <= '0;
      thresh_ff  <= '0;
      mask_ff    <= '0;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        sscd_pkg::ADDR_CTRL: begin
          ctrl_ff <= i_reg_wdata[sscd_pkg::CTRL_W-1:0];
          // A control write also restarts the capture pointer
        end
        sscd_pkg::ADDR_WORDLEN: wordlen_ff <= i_reg_wdata[5:0];
        sscd_pkg::ADDR_DST:     dst_ff     <= i_reg_wdata;
        sscd_pkg::ADDR_COUNT:   count_ff   <= i_reg_wdata;
        sscd_pkg::ADDR_THRESH:  thresh_ff  <= i_reg_wdata;
        sscd_pkg::ADDR_MASK:    mask_ff    <= i_reg_wdata[sscd_pkg::ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Stream port owns the shared pins only while enabled; GPIO gets them otherwise
  assign o_upper_gpio_group_en = !ctrl_ff[sscd_pkg::CTRL_STREAM_EN]; // RL13

  ////////////////////////////////////////////////////////////////////////////
  // Link synchronisers: three-flop chains, first stage feeds only the second
  logic [2:0] sclk_s_ff, lrclk_s_ff, sdat_s_ff, ref_s_ff, sclk_st_ff;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sclk_s_ff  <= '0;
      lrclk_s_ff <= '0;
      sdat_s_ff  <= '0;
      ref_s_ff   <= '0;
      sclk_st_ff <= '0;
    end else begin
      sclk_s_ff  <= {sclk_s_ff[1:0], i_sclk}; // RL19
      lrclk_s_ff <= {lrclk_s_ff[1:0], i_lrclk};
      sdat_s_ff  <= {sdat_s_ff[1:0], i_sdata};
      ref_s_ff   <= {ref_s_ff[1:0], i_master_reference_clock_in};
      sclk_st_ff <= {sclk_st_ff[1:0], i_stream_clk};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master mode clock generation from reference edges
  logic [3:0] half_cnt_ff;
  logic [5:0] bit_cnt_ff;
  logic       m_sclk_ff;
  logic       m_lrclk_ff;
  wire        master   = ctrl_ff[sscd_pkg::CTRL_MASTER];
  wire        i2s_en   = ctrl_ff[sscd_pkg::CTRL_I2S_EN];
  wire        ref_rise = ref_s_ff[1] && !ref_s_ff[2];

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !master || !i2s_en) begin
      half_cnt_ff <= '0;
      bit_cnt_ff  <= '0;
      m_sclk_ff   <= 1'b0;
      m_lrclk_ff  <= 1'b0;
    end else if (ref_rise) begin // RL3
      if (half_cnt_ff == sscd_pkg::SCLK_HALF - 4'h1) begin
        half_cnt_ff <= '0;
        m_sclk_ff   <= !m_sclk_ff;
        if (m_sclk_ff) begin
          // Frame clock changes on falling bit clock
          if (bit_cnt_ff == sscd_pkg::BITS_PER_CH - 6'h1) begin
            bit_cnt_ff <= '0;
            m_lrclk_ff <= !m_lrclk_ff;
          end else begin
            bit_cnt_ff <= bit_cnt_ff + 6'h1;
          end
        end
      end else begin
        half_cnt_ff <= half_cnt_ff + 4'h1;
      end
    end
  end

  assign o_sclk     = m_sclk_ff;
  assign o_lrclk    = m_lrclk_ff;
  assign o_sclk_oe  = master && i2s_en; // RL1
  assign o_lrclk_oe = master && i2s_en;

  ////////////////////////////////////////////////////////////////////////////
  // Audio word capture; bit clock and frame clock chosen by mode
  logic       a_sclk_q_ff;
  logic       a_lr_q_ff;
  logic [31:0] a_shift_ff;
  logic [5:0]  a_cnt_ff;
  sscd_pkg::sscd_word_t a_word_ff;
  wire  a_sclk = master ? m_sclk_ff  : sclk_s_ff[2]; // RL2
  wire  a_lr   = master ? m_lrclk_ff : lrclk_s_ff[2];
  wire  a_rise = a_sclk && !a_sclk_q_ff;
  wire  a_edge = a_rise && (a_lr != a_lr_q_ff);
  wire  [5:0] a_want = (wordlen_ff == '0) ? sscd_pkg::WORD_MAX : wordlen_ff; // RL5
  wire  [5:0] a_keep = (a_cnt_ff > a_want) ? a_want : a_cnt_ff;

  // Aligns captured bits to the top then zero-fills; bytes rounded up
  function automatic logic [31:0] a_align(input logic [31:0] s, input logic [5:0] n,
                                          input logic [5:0] w);
    logic [31:0] v;
    v = (n == '0) ? 32'h0 : (s << (6'd32 - n));
    a_align = v >> (6'd32 - w);
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !i2s_en) begin
      a_sclk_q_ff <= 1'b0;
      a_lr_q_ff   <= 1'b0;
      a_shift_ff  <= '0;
      a_cnt_ff    <= '0;
      a_word_ff   <= '0;
    end else begin
      a_sclk_q_ff     <= a_sclk;
      a_word_ff.valid <= 1'b0;
      if (a_rise) begin
        a_lr_q_ff <= a_lr;
        if (a_edge) begin
          // Frame ended: emit the previous channel, MSB sits highest when the length is whole bytes
          a_word_ff.valid  <= (a_cnt_ff != '0);
          a_word_ff.data   <= a_align(a_shift_ff, a_keep, a_want) << // RL6
                              (6'd32 - ({1'b0, a_want[5:3]} + {5'h0, |a_want[2:0]}) * 6'd8);
          a_word_ff.nbytes <= 3'({1'b0, a_want[5:3]} + {5'h0, |a_want[2:0]});
          a_shift_ff       <= {31'h0, sdat_s_ff[2]};
          a_cnt_ff         <= 6'h1;
        end else if (a_cnt_ff < a_want) begin
          a_shift_ff <= {a_shift_ff[30:0], sdat_s_ff[2]}; // RL4
          a_cnt_ff   <= a_cnt_ff + 6'h1;
        end else begin
          a_cnt_ff   <= a_cnt_ff + 6'h1; // RL7
          if (a_cnt_ff == 6'h3F) a_cnt_ff <= a_cnt_ff;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stream port: bytes sampled on rising stream clock seen through synchroniser
  logic [7:0] s_dat_ff;
  logic       s_val_ff, s_psync_ff;
  logic [7:0] s_len_ff;
  logic       s_inpkt_ff;
  logic       s_sync_bad, s_size_bad;
  sscd_pkg::sscd_word_t s_word_ff;
  wire  stream_en = ctrl_ff[sscd_pkg::CTRL_STREAM_EN];
  wire  s_rise    = sclk_st_ff[1] && !sclk_st_ff[2];
  wire  [7:0] pkt_len = ctrl_ff[sscd_pkg::CTRL_PKT204] ? sscd_pkg::PKT_LEN_B
                                                       : sscd_pkg::PKT_LEN_A; // RL9

  // Data pins are stable around the stream clock edge; 20 Mbit/s limit keeps it slow
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_dat_ff   <= '0;
      s_val_ff   <= 1'b0;
      s_psync_ff <= 1'b0;
    end else begin
      s_val_ff <= 1'b0;
      if (s_rise && stream_en && i_stream_byte_valid) begin // RL8
        s_val_ff   <= 1'b1;
        s_dat_ff   <= i_stream_data;
        s_psync_ff <= i_stream_packet_start_flag; // RL10
      end
    end
  end

  always_comb begin
    s_sync_bad = s_val_ff && s_psync_ff && (s_dat_ff != sscd_pkg::SYNC_A) &&
                 !(ctrl_ff[sscd_pkg::CTRL_PKT204] && (s_dat_ff == sscd_pkg::SYNC_B)); // RL18
    s_size_bad = s_val_ff && s_psync_ff && s_inpkt_ff && (s_len_ff != pkt_len);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !stream_en) begin
      s_len_ff   <= '0;
      s_inpkt_ff <= 1'b0;
    end else if (s_val_ff) begin
      if (s_psync_ff) begin
        s_len_ff   <= 8'h1;
        s_inpkt_ff <= 1'b1;
      end else if (s_len_ff != 8'hFF) begin
        s_len_ff <= s_len_ff + 8'h1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sync_err_ff <= '0;
      size_err_ff <= '0;
    end else begin
      if (s_sync_bad) sync_err_ff <= sync_err_ff + 32'h1; // RL11
      if (s_size_bad) size_err_ff <= size_err_ff + 32'h1; // RL18
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      s_word_ff <= '0;
    end else begin
      s_word_ff.valid  <= s_val_ff;
      s_word_ff.data   <= {s_dat_ff, 24'h0};
      s_word_ff.nbytes <= 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture DMA: one word per cycle, never stalls the sources
  sscd_pkg::sscd_mem_wr_t mem_ff;
  sscd_pkg::sscd_word_t   src;
  logic [31:0]            done_ff;
  logic [31:0]            nxt_offs;
  logic                   wrap;
  logic [2:0]             mem_nb_ff;
  wire                    dma_en = ctrl_ff[sscd_pkg::CTRL_DMA_EN];
  wire                    circ   = ctrl_ff[sscd_pkg::CTRL_CIRC];

  // Audio and stream are never captured together in practice; audio has priority
  always_comb begin
    src  = a_word_ff.valid ? a_word_ff : s_word_ff; // RL15
    nxt_offs = offs_ff + {29'h0, src.nbytes};
    wrap = circ && (nxt_offs >= count_ff);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || wr_ctrl) begin
      mem_ff  <= '0;
      mem_nb_ff <= '0;
      offs_ff <= '0;
      done_ff <= '0;
    end else begin
      mem_ff.valid <= 1'b0;
      if (dma_en && src.valid && (circ || done_ff < count_ff)) begin
        mem_ff.valid <= 1'b1;
        mem_ff.addr  <= dst_ff + offs_ff; // RL14
        mem_ff.data  <= src.data;
        mem_nb_ff    <= src.nbytes;
        offs_ff      <= wrap ? 32'h0 : nxt_offs; // RL16
        done_ff      <= done_ff + {29'h0, src.nbytes};
      end
    end
  end

  assign o_mem_wr = mem_ff;

  // Fill level: bytes written and not yet consumed; software reads level
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || wr_ctrl) begin
      level_ff <= '0;
    end else if (i_reg_wr && hit(i_reg_addr, sscd_pkg::ADDR_LEVEL)) begin
      level_ff <= (i_reg_wdata > level_ff) ? 32'h0 : level_ff - i_reg_wdata;
    end else if (mem_ff.valid && circ) begin
      level_ff <= level_ff + {29'h0, mem_nb_ff};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events, sticky status, write-one-to-clear; set wins over clear
  always_comb begin
    ev = '0;
    ev[sscd_pkg::ST_FILL]     = circ && mem_ff.valid && (level_ff >= thresh_ff);
    ev[sscd_pkg::ST_OVERFLOW] = circ && mem_ff.valid && (level_ff >= count_ff); // RL17
    ev[sscd_pkg::ST_DONE]     = !circ && mem_ff.valid && (done_ff >= count_ff);
    ev[sscd_pkg::ST_SYNCERR]  = s_sync_bad;
    ev[sscd_pkg::ST_SIZEERR]  = s_size_bad;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~((i_reg_wr && hit(i_reg_addr, sscd_pkg::ADDR_STATUS))
                   ? i_reg_wdata[sscd_pkg::ST_W-1:0] : '0)) | ev; // RL16
    end
  end

  assign o_irq = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_reg_rdata <= '0;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        sscd_pkg::ADDR_CTRL:    o_reg_rdata <= {26'h0, ctrl_ff};
        sscd_pkg::ADDR_WORDLEN: o_reg_rdata <= {26'h0, wordlen_ff};
        sscd_pkg::ADDR_DST:     o_reg_rdata <= dst_ff;
        sscd_pkg::ADDR_COUNT:   o_reg_rdata <= count_ff;
        sscd_pkg::ADDR_STATUS:  o_reg_rdata <= {27'h0, status_ff};
        sscd_pkg::ADDR_MASK:    o_reg_rdata <= {27'h0, mask_ff};
        sscd_pkg::ADDR_WRPTR:   o_reg_rdata <= dst_ff + offs_ff;
        sscd_pkg::ADDR_SYNCERR: o_reg_rdata <= sync_err_ff;
        sscd_pkg::ADDR_SIZEERR: o_reg_rdata <= size_err_ff;
        sscd_pkg::ADDR_LEVEL:   o_reg_rdata <= level_ff;
        sscd_pkg::ADDR_THRESH:  o_reg_rdata <= thresh_ff;
        default:                o_reg_rdata <= 32'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: tb/sscd_capture_sva.sv
// Port-level checks for the capture block
`timescale 1ns/1ps
`default_nettype none
module sscd_capture_sva (
  // Clock and reset
  input wire logic                   i_core_clk,
  input wire logic                   i_reset_n,
  // Register port
  input wire logic [3:0]             i_reg_addr,
  input wire logic [31:0]            i_reg_wdata,
  input wire logic                   i_reg_wr,
  // Watched pins
  input wire logic                   o_irq,
  input wire logic                   o_sclk_oe,
  input wire logic                   o_lrclk_oe,
  input wire logic                   i_stream_clk,
  input wire logic                   i_stream_byte_valid,
  input wire logic                   o_upper_gpio_group_en,
  input wire sscd_pkg::sscd_mem_wr_t o_mem_wr
);
  logic [5:0]  ctrl_ff;
  logic [31:0] dst_ff;
  logic [31:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of settings, taken from the write strobe alone
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_ff <= 6'h00;
      dst_ff  <= 32'h0;
      cnt_ff  <= 32'h0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == sscd_pkg::ADDR_CTRL) ctrl_ff <= i_reg_wdata[5:0];
      if (i_reg_addr == sscd_pkg::ADDR_DST) dst_ff <= i_reg_wdata;
      if (i_reg_addr == sscd_pkg::ADDR_COUNT) cnt_ff <= i_reg_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_ctrl_wr;
    i_reg_wr && (i_reg_addr == sscd_pkg::ADDR_CTRL);
  endsequence
  sequence s_byte_seen;
    $rose(i_stream_clk) && ctrl_ff[sscd_pkg::CTRL_STREAM_EN];
  endsequence
  AST_GPIO_EXCL: assert property (s_ctrl_wr |-> ##2
    (o_upper_gpio_group_en != ctrl_ff[sscd_pkg::CTRL_STREAM_EN])) else $error("gpio clash");
  AST_LINK_OE: assert property (s_ctrl_wr |-> ##2 (o_sclk_oe ==
    (ctrl_ff[sscd_pkg::CTRL_MASTER] && ctrl_ff[sscd_pkg::CTRL_I2S_EN]))) else $error("bad oe");
  AST_OE_PAIR: assert property (o_sclk_oe |-> o_lrclk_oe)
    else $error("frame clock not driven");
  AST_ADDR_RANGE: assert property (o_mem_wr.valid |-> (o_mem_wr.addr >= dst_ff)
    && ((o_mem_wr.addr - dst_ff) < cnt_ff)) else $error("write outside buffer");
  AST_STREAM_ZERO: assert property (o_mem_wr.valid && ctrl_ff[sscd_pkg::CTRL_STREAM_EN]
    |-> (o_mem_wr.data[23:0] == 24'h0)) else $error("stream word low bits set");
  AST_STREAM_TAKE: assert property (s_byte_seen ##0 i_stream_byte_valid
    |-> ##[2:9] o_mem_wr.valid) else $error("valid byte lost");
  AST_STREAM_SKIP: assert property (s_byte_seen ##0 !i_stream_byte_valid
    |=> (!o_mem_wr.valid) [*8]) else $error("invalid byte written");
  AST_MEM_PULSE: assert property (o_mem_wr.valid |=> !o_mem_wr.valid)
    else $error("write pulse too long");
  AST_IRQ_MASK: assert property (i_reg_wr && (i_reg_addr == sscd_pkg::ADDR_MASK)
    && (i_reg_wdata[4:0] == 5'h00) |=> !o_irq) else $error("masked irq high");
endmodule
bind sscd_capture sscd_capture_sva i_sscd_capture_sva (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .o_irq(o_irq), .o_sclk_oe(o_sclk_oe),
  .o_lrclk_oe(o_lrclk_oe), .i_stream_clk(i_stream_clk),
  .i_stream_byte_valid(i_stream_byte_valid),
  .o_upper_gpio_group_en(o_upper_gpio_group_en), .o_mem_wr(o_mem_wr));
`default_nettype wire

// File: tb/sscd_src_model.sv
// Behavioural audio transmitter and stream source
`timescale 1ns/1ps
`default_nettype none
module sscd_src_model (
  // Clock
  input  wire logic       i_core_clk,
  // Serial audio link
  output logic            o_sclk = 1'b0,
  output logic            o_lrclk = 1'b0,
  output logic            o_sdata = 1'b0,
  // Parallel stream port
  output logic            o_stream_clk = 1'b0,
  output logic [7:0]      o_stream_data = 8'h00,
  output logic            o_stream_byte_valid = 1'b0,
  output logic            o_stream_packet_start_flag = 1'b0
);
  // Bit clock runs only inside frames; data launched while it is low
  task automatic i2s_frame(input logic [31:0] w, input int nbits, input logic lr);
    for (int i = nbits - 1; i >= 0; i--) begin
      @(posedge i_core_clk);
      o_sclk  <= 1'b0;
      o_lrclk <= lr;
      o_sdata <= w[i];
      repeat (2) @(posedge i_core_clk);
      o_sclk <= 1'b1;
      @(posedge i_core_clk);
    end
    @(posedge i_core_clk);
    o_sclk  <= 1'b0;
    o_sdata <= ~w[0];
  endtask
  // Ten core cycles per byte, far below the source rate ceiling
  task automatic put_byte(input logic [7:0] b, input logic v, input logic s);
    @(posedge i_core_clk);
    o_stream_clk               <= 1'b0;
    o_stream_data              <= b;
    o_stream_byte_valid        <= v;
    o_stream_packet_start_flag <= s;
    repeat (5) @(posedge i_core_clk);
    o_stream_clk <= 1'b1;
    repeat (4) @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// File: tb/test_sscd_capture.sv
// Self-checking bench for the capture block
`timescale 1ns/1ps
`default_nettype none
module test_sscd_capture;
  localparam logic [31:0] DST = 32'h0000_1000;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, ref_clk = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        irq, sclk, sclk_oe, lrclk, lrclk_oe, gpio_en;
  wire logic   m_sclk, m_lrclk, m_sdata, s_clk, s_valid, s_flag;
  wire logic [7:0] s_data;
  sscd_pkg::sscd_mem_wr_t mem;
  logic [63:0] exp_mem_q[$], exp_rd_q[$];
  int          n_fail = 0, total_checks = 0, seed = 32'hacb6, off;
  always #50 clk = ~clk;
  always #120 ref_clk = ~ref_clk;
  sscd_capture i_sscd_capture (.i_core_clk(clk), .i_reset_n(rst_n), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq),
    .i_master_reference_clock_in(ref_clk), .i_sclk(m_sclk), .i_lrclk(m_lrclk),
    .i_sdata(m_sdata), .o_sclk(sclk), .o_sclk_oe(sclk_oe), .o_lrclk(lrclk),
    .o_lrclk_oe(lrclk_oe), .i_stream_clk(s_clk), .i_stream_data(s_data),
    .i_stream_byte_valid(s_valid), .i_stream_packet_start_flag(s_flag),
    .o_upper_gpio_group_en(gpio_en), .o_mem_wr(mem));
  sscd_src_model i_sscd_src_model (.i_core_clk(clk), .o_sclk(m_sclk), .o_lrclk(m_lrclk),
    .o_sdata(m_sdata), .o_stream_clk(s_clk), .o_stream_data(s_data),
    .o_stream_byte_valid(s_valid), .o_stream_packet_start_flag(s_flag));
  ////////////////////////////////////////////////////////////////////////////
  task automatic bad(input string what, input logic [63:0] got, input logic [63:0] exp);
    n_fail++;
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
  endtask
  task automatic cmp_mem(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) bad("mem", got, exp);
  endtask
  task automatic cmp_reg(input logic [31:0] got, input logic [63:0] e);
    total_checks++;
    if ((got & e[31:0]) !== e[63:32]) bad("reg", {32'h0, got}, e);
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) bad("flag", {63'h0, got}, {63'h0, exp});
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_rd_q.push_back({e & m, m});
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic send_pkt(input logic [7:0] first, input int len);
    logic [7:0] b;
    for (int k = 0; k < len; k++) begin
      b = 8'($random(seed));
      if (k != 0 && b[2:0] == 3'h0) i_sscd_src_model.put_byte(~b, 1'b0, 1'b0);
      if (k == 0) b = first;
      exp_mem_q.push_back({DST + 32'(off % 64), b, 24'h0});
      off++;
      i_sscd_src_model.put_byte(b, 1'b1, k == 0);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) cmp_reg(rdata, exp_rd_q.size() ? exp_rd_q.pop_front() : 'x);
    if (mem.valid) cmp_mem({mem.addr, mem.data}, exp_mem_q.size() ? exp_mem_q.pop_front() : 'x);
  end
  initial begin
    #3000000;
    bad("watchdog", 64'h0, 64'h0);
    conclude();
  end
  initial begin
    logic [31:0] w, d;
    int wl, nb, len, edges;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    cmp_bit(gpio_en, 1'b1);
    reg_rd(sscd_pkg::ADDR_STATUS, 32'h0, 32'hFFFF_FFFF);
    reg_rd(4'hF, 32'h0, 32'hFFFF_FFFF);
    $display("test reset done");
    for (int c = 0; c < 3; c++) begin
      wl = (c == 0) ? 0 : (c == 1) ? 8 : 24;
      nb = (c == 0) ? 32 : 16;
      len = (wl == 0) ? nb : wl;
      reg_wr(sscd_pkg::ADDR_CTRL, 32'h0);
      reg_wr(sscd_pkg::ADDR_WORDLEN, 32'(wl));
      reg_wr(sscd_pkg::ADDR_DST, DST);
      reg_wr(sscd_pkg::ADDR_COUNT, 32'h40);
      reg_wr(sscd_pkg::ADDR_CTRL, 32'h21);
      off = 0;
      for (int k = 0; k < 2; k++) begin
        w = $random(seed);
        d = (w << (32 - nb)) & ~(32'hFFFF_FFFF >> len);
        exp_mem_q.push_back({DST + 32'(off), d});
        off += (len + 7) / 8;
        i_sscd_src_model.i2s_frame(w, nb, k[0]);
      end
      i_sscd_src_model.i2s_frame(32'h0, 1, 1'b0);
      repeat (20) @(posedge clk);
      $display("test audio case %0d done", c);
    end
    reg_wr(sscd_pkg::ADDR_CTRL, 32'h03);
    edges = 0;
    repeat (40) begin
      @(negedge clk);
      if (sclk !== w[0]) edges++;
      w[0] = sclk;
    end
    cmp_bit(sclk_oe, 1'b1);
    cmp_bit(lrclk_oe, 1'b1);
    cmp_bit(edges > 4, 1'b1);
    reg_wr(sscd_pkg::ADDR_CTRL, 32'h01);
    @(negedge clk);
    cmp_bit(sclk_oe, 1'b0);
    cmp_bit(lrclk_oe, 1'b0);
    $display("test master mode done");
    reg_wr(sscd_pkg::ADDR_THRESH, 32'h10);
    reg_wr(sscd_pkg::ADDR_CTRL, 32'h2C);
    @(negedge clk);
    cmp_bit(gpio_en, 1'b0);
    off = 0;
    send_pkt(8'h47, 188);
    send_pkt(8'h12, 10);
    send_pkt(8'h47, 1);
    repeat (20) @(posedge clk);
    reg_rd(sscd_pkg::ADDR_SYNCERR, 32'h1, 32'hFFFF_FFFF);
    reg_rd(sscd_pkg::ADDR_SIZEERR, 32'h1, 32'hFFFF_FFFF);
    reg_rd(sscd_pkg::ADDR_WRPTR, DST + 32'(off % 64), 32'hFFFF_FFFF);
    reg_rd(sscd_pkg::ADDR_STATUS, 32'h1B, 32'h1B);
    reg_wr(sscd_pkg::ADDR_MASK, 32'h2);
    @(negedge clk);
    cmp_bit(irq, 1'b1);
    reg_wr(sscd_pkg::ADDR_MASK, 32'h0);
    @(negedge clk);
    cmp_bit(irq, 1'b0);
    reg_wr(sscd_pkg::ADDR_MASK, 32'h2);
    reg_wr(sscd_pkg::ADDR_STATUS, 32'h1F);
    @(negedge clk);
    cmp_bit(irq, 1'b0);
    reg_rd(sscd_pkg::ADDR_STATUS, 32'h0, 32'h1A);
    $display("test stream 188 done");
    reg_wr(sscd_pkg::ADDR_MASK, 32'h18);
    // Stream off forgets the open one-byte packet, else a size error
    reg_wr(sscd_pkg::ADDR_CTRL, 32'h0);
    reg_wr(sscd_pkg::ADDR_CTRL, 32'h3C);
    off = 0;
    send_pkt(8'hB8, 204);
    send_pkt(8'h47, 204);
    send_pkt(8'h47, 1);
    repeat (20) @(negedge clk);
    cmp_bit(irq, 1'b0);
    reg_rd(sscd_pkg::ADDR_STATUS, 32'h0, 32'h18);
    repeat (10) @(posedge clk);
    if (exp_mem_q.size() != 0) bad("missing writes", 64'(exp_mem_q.size()), 64'h0);
    $display("test stream 204 done");
    conclude();
  end
endmodule
`default_nettype wire
